//--- sps_pkg.sv
// constants, register map and types of the spi serial port core
package sps_pkg;
   // bus and register map
   localparam int         SPS_AW          = 8;
   localparam logic [7:0] SPS_CTRL_OFS    = 8'h14;
   localparam logic [7:0] SPS_STAT_OFS    = 8'h94;
   localparam logic [7:0] SPS_BUF_OFS     = 8'h18;
   localparam logic [7:0] SPS_IRQ_ST_OFS  = 8'h1c;
   localparam logic [7:0] SPS_IRQ_MSK_OFS = 8'h20;
   // values after reset
   localparam logic [7:0] SPS_CTRL_RST    = 8'h00;
   localparam logic [1:0] SPS_STAT_RST    = 2'h0;
   localparam logic [7:0] SPS_BUF_RST     = 8'h00;
   // mode field codes
   localparam logic [3:0] SPS_MODE_D16    = 4'h1;
   localparam logic [3:0] SPS_MODE_D64    = 4'h2;
   localparam logic [3:0] SPS_MODE_TMR    = 4'h3;
   localparam logic [3:0] SPS_MODE_SLV_SS = 4'h4;
   localparam logic [3:0] SPS_MODE_SLV    = 4'h5;
   // clock division and cycle counts
   localparam int         SPS_DIV16       = 16;
   localparam int         SPS_DIV64       = 64;
   localparam logic [5:0] SPS_HALF16      = 6'(SPS_DIV16 / 2);
   localparam logic [5:0] SPS_HALF64      = 6'(SPS_DIV64 / 2);
   // serial clock edge indices of one byte
   localparam logic [4:0] SPS_EDGE_LAST   = 5'h0f;
   localparam logic [4:0] SPS_EDGE_END    = 5'h10;
   localparam logic [4:0] SPS_SAMP_SPAN   = 5'h0e;
   localparam logic [4:0] SPS_SHIFT_LAST  = 5'h0e;

   typedef struct packed {
      logic       write_collision;
      logic       ovf;
      logic       en;
      logic       clock_idle_polarity;
      logic [3:0] mode;
   } sps_ctrl_t;

   typedef struct packed {
      logic sample_phase;
      logic cke;
   } sps_stat_t;

   typedef enum logic [1:0] {
      SPS_IDLE = 2'b01,
      SPS_RUN  = 2'b10
   } sps_state_t;
endpackage

//--- sps_core.sv
// spi serial port core with apb registers and pin synchronisers
//
// Chosen here: register access over APB.

module sps_sync #(
   parameter int W = 1
) (
   input  wire logic         CLK_I,
   input  wire logic         RESET_I,
   input  wire logic [W-1:0] D_I,
   output logic      [W-1:0] Q_O
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   logic [W-1:0] q_reg;
   logic [W-1:0] q_next;

   // glitch filter: accept only when stages two and three agree
   always_comb begin
      q_next = (s2_reg == s3_reg) ? s3_reg : q_reg;
   end

   always_ff @(posedge CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         q_reg  <= '0;
      end else begin
         s1_reg <= D_I;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         q_reg  <= q_next;
      end
   end

   assign Q_O = q_reg;
endmodule

module sps_core (
   // clock and reset
   input  wire logic                    CLK_I,
   input  wire logic                    RESET_I,
   // apb slave
   input  wire logic                    PSEL_I,
   input  wire logic                    PENABLE_I,
   input  wire logic                    PWRITE_I,
   input  wire logic [sps_pkg::SPS_AW-1:0] PADDR_I,
   input  wire logic [31:0]             PWDATA_I,
   output logic      [31:0]             PRDATA_O,
   output logic                         PREADY_O,
   output logic                         PSLVERR_O,
   // timer two output pulse
   input  wire logic                    TIMER_TWO_I,
   // spi pins
   input  wire logic                    SCK_I,
   output logic                         SCK_O,
   output logic                         SCK_OE_O,
   input  wire logic                    SDI_I,
   output logic                         SDO_O,
   output logic                         SDO_OE_O,
   input  wire logic                    SS_N_I,
   // interrupt
   output logic                         IRQ_O
);
   import sps_pkg::*;

   sps_ctrl_t  ctrl_reg, ctrl_next;
   sps_stat_t  stat_reg, stat_next;
   sps_state_t st_reg, st_next;
   logic [7:0] buf_reg, buf_next;
   logic [7:0] sr_reg, sr_next;
   logic [4:0] e_reg, e_next;
   logic [5:0] div_reg, div_next;
   logic       bf_reg, bf_next;
   logic       ist_reg, ist_next;
   logic       msk_reg, msk_next;
   logic       ob_reg, ob_next;
   logic       sck_reg, sck_next;
   logic       sckd_reg;
   logic [31:0] prd_reg, prd_next;
   logic       err_reg, err_next;
   logic [2:0] pins_f;
   logic       sck_f, sdi_f, ss_n_f;
   logic       master, slave, sel, busy;
   logic       half_tick, edge_v, samp, sh, done, smp_eff;
   logic [4:0] bs, bo;
   logic       setup, acc_wr, acc_rd, hit, buf_wr;

   sps_sync #(.W(3)) u_sync (
      .CLK_I   (CLK_I),
      .RESET_I (RESET_I),
      .D_I     ({SCK_I, SDI_I, SS_N_I}),
      .Q_O     (pins_f)
   );
   assign sck_f  = pins_f[2];
   assign sdi_f  = pins_f[1];
   assign ss_n_f = pins_f[0];

   // mode decode
   always_comb begin
      master = ctrl_reg.en && (ctrl_reg.mode == SPS_MODE_D16 ||
               ctrl_reg.mode == SPS_MODE_D64 ||
               ctrl_reg.mode == SPS_MODE_TMR);
      slave  = ctrl_reg.en && (ctrl_reg.mode == SPS_MODE_SLV_SS ||
               ctrl_reg.mode == SPS_MODE_SLV);
      // free select pin ignored in the select-less slave mode
      sel    = (ctrl_reg.mode == SPS_MODE_SLV) || !ss_n_f;
      busy   = (st_reg == SPS_RUN) || (slave && e_reg != 5'h00);
      unique case (ctrl_reg.mode)
         SPS_MODE_D16: half_tick = (div_reg == SPS_HALF16 - 6'h01);
         SPS_MODE_D64: half_tick = (div_reg == SPS_HALF64 - 6'h01);
         default:      half_tick = TIMER_TWO_I;
      endcase
      // slave side always samples mid-bit
      smp_eff = master && stat_reg.sample_phase;
      bs = {4'h0, ~stat_reg.cke} + {4'h0, smp_eff};
      bo = stat_reg.cke ? 5'h01 : 5'h02;
      samp = e_reg >= bs && e_reg <= bs + SPS_SAMP_SPAN &&
             e_reg[0] == bs[0];
      sh   = e_reg >= bo && e_reg <= SPS_SHIFT_LAST &&
             e_reg[0] == bo[0];
   end

   // apb decode
   always_comb begin
      setup  = PSEL_I && !PENABLE_I;
      acc_wr = PSEL_I && PENABLE_I && PWRITE_I;
      acc_rd = PSEL_I && PENABLE_I && !PWRITE_I;
      hit    = PADDR_I == SPS_CTRL_OFS || PADDR_I == SPS_STAT_OFS ||
               PADDR_I == SPS_BUF_OFS || PADDR_I == SPS_IRQ_ST_OFS ||
               PADDR_I == SPS_IRQ_MSK_OFS;
      buf_wr = acc_wr && PADDR_I == SPS_BUF_OFS;
      prd_next = prd_reg;
      err_next = 1'b0;
      if (setup) begin
         err_next = !hit;
         prd_next = 32'h0;
         case (PADDR_I)
            SPS_CTRL_OFS:    prd_next[7:0] = ctrl_reg;
            SPS_STAT_OFS:    prd_next[7:0] = {stat_reg, 5'h00,
                                             bf_reg};
            SPS_BUF_OFS:     prd_next[7:0] = buf_reg;
            SPS_IRQ_ST_OFS:  prd_next[0]   = ist_reg;
            SPS_IRQ_MSK_OFS: prd_next[0]   = msk_reg;
            default:         prd_next      = 32'h0;
         endcase
      end
   end

   // shift engine and registers
   always_comb begin
      ctrl_next = ctrl_reg;
      stat_next = stat_reg;
      buf_next  = buf_reg;
      bf_next   = bf_reg;
      ist_next  = ist_reg;
      msk_next  = msk_reg;
      st_next   = st_reg;
      e_next    = e_reg;
      sr_next   = sr_reg;
      ob_next   = ob_reg;
      sck_next  = sck_reg;
      div_next  = div_reg;
      edge_v    = 1'b0;
      done      = 1'b0;
      // clears first so a same-cycle set wins
      if (acc_rd && PADDR_I == SPS_BUF_OFS)
         bf_next = 1'b0;
      if (acc_wr && PADDR_I == SPS_IRQ_ST_OFS && PWDATA_I[0])
         ist_next = 1'b0;
      if (st_reg == SPS_RUN) begin
         if (half_tick) begin
            div_next = 6'h00;
            edge_v   = 1'b1;
            if (e_reg <= SPS_EDGE_LAST)
               sck_next = ~sck_reg;
         end else begin
            div_next = div_reg + 6'h01;
         end
      end else begin
         sck_next = ctrl_reg.clock_idle_polarity;
         if (slave && sel)
            edge_v = sck_f != sckd_reg;
      end
      if (edge_v) begin
         if (samp)
            sr_next = {sr_reg[6:0], sdi_f};
         if (sh)
            ob_next = samp ? sr_reg[6] : sr_reg[7];
         e_next = e_reg + 5'h01;
         done = e_reg == (master ? SPS_EDGE_END : SPS_EDGE_LAST);
      end
      if (done) begin
         buf_next = sr_next;
         bf_next  = 1'b1;
         ist_next = 1'b1;
         e_next   = 5'h00;
         st_next  = SPS_IDLE;
         sck_next = ctrl_reg.clock_idle_polarity;
      end
      // deselect aborts a partial slave byte
      if (ctrl_reg.mode == SPS_MODE_SLV_SS && ss_n_f)
         e_next = 5'h00;
      if (!ctrl_reg.en) begin
         st_next = SPS_IDLE;
         e_next  = 5'h00;
      end
      if (acc_wr && PADDR_I == SPS_CTRL_OFS)
         ctrl_next = PWDATA_I[7:0];
      if (acc_wr && PADDR_I == SPS_STAT_OFS)
         stat_next = PWDATA_I[7:6];
      if (acc_wr && PADDR_I == SPS_IRQ_MSK_OFS)
         msk_next = PWDATA_I[0];
      if (buf_wr) begin
         if (busy) begin
            // colliding write is dropped, shift keeps going
            ctrl_next.write_collision = 1'b1;
         end else begin
            buf_next = PWDATA_I[7:0];
            sr_next  = PWDATA_I[7:0];
            ob_next  = PWDATA_I[7];
            if (master) begin
               st_next  = SPS_RUN;
               e_next   = 5'h00;
               div_next = 6'h00;
            end
         end
      end
   end

   always_ff @(posedge CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         ctrl_reg <= SPS_CTRL_RST;
         stat_reg <= SPS_STAT_RST;
         buf_reg  <= SPS_BUF_RST;
         sr_reg   <= SPS_BUF_RST;
         bf_reg   <= 1'b0;
         ist_reg  <= 1'b0;
         msk_reg  <= 1'b0;
         st_reg   <= SPS_IDLE;
         e_reg    <= 5'h00;
         ob_reg   <= 1'b0;
         sck_reg  <= 1'b0;
         sckd_reg <= 1'b0;
         div_reg  <= 6'h00;
         prd_reg  <= 32'h0;
         err_reg  <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         stat_reg <= stat_next;
         buf_reg  <= buf_next;
         sr_reg   <= sr_next;
         bf_reg   <= bf_next;
         ist_reg  <= ist_next;
         msk_reg  <= msk_next;
         st_reg   <= st_next;
         e_reg    <= e_next;
         ob_reg   <= ob_next;
         sck_reg  <= sck_next;
         sckd_reg <= sck_f;
         div_reg  <= div_next;
         prd_reg  <= prd_next;
         err_reg  <= err_next;
      end
   end

   // zero wait state: answer in the first access cycle
   assign PREADY_O  = 1'b1;
   assign PRDATA_O  = prd_reg;
   assign PSLVERR_O = err_reg && PSEL_I && PENABLE_I;
   assign SCK_O     = sck_reg;
   assign SCK_OE_O  = master;
   assign SDO_O     = ob_reg;
   assign SDO_OE_O  = master || (slave && sel);
   assign IRQ_O     = ist_reg && msk_reg;

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RESET_I);

   rx_load_a: assert property (done |=> bf_reg && ist_reg &&
      buf_reg == $past(sr_next))
      else $error("received byte not loaded");
   tx_load_a: assert property (buf_wr && !busy |=>
      buf_reg == $past(PWDATA_I[7:0]) && sr_reg == buf_reg)
      else $error("buffer write not mirrored");
   sr_move_a: assert property ($changed(sr_reg) |->
      $past(edge_v) || $past(buf_wr))
      else $error("shift register moved without cause");
   stat_ro_a: assert property (setup && PADDR_I == SPS_STAT_OFS
      |=> PRDATA_O[5:1] == 5'h00 && PRDATA_O[0] == $past(bf_reg))
      else $error("status low bits wrong");
   ctrl_rw_a: assert property (acc_wr && PADDR_I == SPS_CTRL_OFS
      && !buf_wr |=> ctrl_reg == $past(PWDATA_I[7:0]))
      else $error("control write lost");
   bf_clr_a: assert property (acc_rd && PADDR_I == SPS_BUF_OFS &&
      !done |=> !bf_reg)
      else $error("buffer full not cleared");
   pins_off_a: assert property (!ctrl_reg.en |->
      !SCK_OE_O && !SDO_OE_O)
      else $error("pins driven while disabled");
   idle_pol_a: assert property (st_reg == SPS_IDLE &&
      $past(st_reg) == SPS_IDLE && $stable(ctrl_reg.clock_idle_polarity)
      |-> SCK_O == ctrl_reg.clock_idle_polarity)
      else $error("clock idle level wrong");
   div16_a: assert property ($rose(st_reg == SPS_RUN) &&
      ctrl_reg.mode == SPS_MODE_D16 |->
      (SCK_O == ctrl_reg.clock_idle_polarity) [*8] ##1 SCK_O != ctrl_reg.clock_idle_polarity)
      else $error("divide by 16 half period wrong");
   div64_a: assert property ($rose(st_reg == SPS_RUN) &&
      ctrl_reg.mode == SPS_MODE_D64 |->
      ##31 SCK_O == ctrl_reg.clock_idle_polarity ##1 SCK_O != ctrl_reg.clock_idle_polarity)
      else $error("divide by 64 half period wrong");
   ss_off_a: assert property (ctrl_reg.mode == SPS_MODE_SLV_SS &&
      ss_n_f |-> !SDO_OE_O)
      else $error("slave drives while deselected");
   out_edge_a: assert property ($changed(ob_reg) |->
      $past(edge_v && sh) || $past(buf_wr))
      else $error("output changed off its edge");
   // a byte completing in the collision cycle still lands
   write_collision_a: assert property (buf_wr && busy |=> ctrl_reg.write_collision &&
      buf_reg == $past(done ? sr_next : buf_reg))
      else $error("collision not flagged");

   m_done_c: cover property (done && master);
   s_done_c: cover property (done && slave);
   write_collision_c:   cover property (buf_wr && busy);
   irq_c:    cover property ($rose(IRQ_O));
endmodule

//--- sps_far_end.sv
// far-side spi shifter model answering on the serial clock line
module sps_far_end (
   // serial line
   input  wire logic       sck_i,
   input  wire logic       sel_i,
   input  wire logic       cke_i,
   input  wire logic       mosi_i,
   // byte to send and byte received
   input  wire logic [7:0] tx_i,
   output logic            miso_o,
   output logic      [7:0] rx_o
);
   logic [7:0] sh;
   logic [4:0] n;

   always @(posedge sel_i) begin
      sh = tx_i;
      n = 5'h00;
   end

   // samples on one edge kind, shifts on the other
   always @(sck_i) begin
      if (sel_i) begin
         if (n[0] == !cke_i) rx_o = {rx_o[6:0], mosi_i};
         else if (n != 5'h00) sh = {sh[6:0], 1'b0};
         n = n + 5'h01;
      end
   end

   // released line shows the inverse so a stale bit never passes
   assign miso_o = sel_i ? sh[7] : ~sh[7];
endmodule

//--- spi_serial_port_core_bench.sv
// self-checking bench of the spi serial port core
module spi_serial_port_core_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import sps_pkg::*;
   logic        clk, rst, psel, pen, pwr, ext_sck, ss_n, sel, cke;
   logic        prdy, perr, sck_o, sck_oe, sdo, sdo_oe, irq, miso, sck_w;
   logic        er;
   logic        t2 = 1'b0;
   logic        sck_q = 1'b0;
   logic [7:0]  paddr, ptx, prx;
   logic [31:0] pwd, prd, rd;
   logic [3:0]  tcnt = 4'h0;
   int          failures, samples_checked;
   int          cyc = 0;
   int          tog = 0;
   int          tt [0:511];

   sps_core i_dut (.CLK_I(clk), .RESET_I(rst), .PSEL_I(psel),
      .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwd),
      .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr), .TIMER_TWO_I(t2),
      .SCK_I(sck_w), .SCK_O(sck_o), .SCK_OE_O(sck_oe), .SDI_I(miso),
      .SDO_O(sdo), .SDO_OE_O(sdo_oe), .SS_N_I(ss_n), .IRQ_O(irq));
   assign sck_w = sck_oe ? sck_o : ext_sck;
   sps_far_end i_far (.sck_i(sck_w), .sel_i(sel), .cke_i(cke),
      .mosi_i(sdo_oe ? sdo : 1'b1), .tx_i(ptx), .miso_o(miso), .rx_o(prx));

   initial begin
      clk = 0;
      forever #2 clk = ~clk;
   end

   // timer pulse every 16 cycles; serial clock toggle times logged
   always @(posedge clk) begin
      cyc <= cyc + 1;
      tcnt <= tcnt + 4'h1;
      t2 <= (tcnt == 4'hf);
      if (sck_o !== sck_q) begin
         tt[tog] <= cyc;
         tog <= tog + 1;
      end
      sck_q <= sck_o;
   end

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwd <= d;
      @(posedge clk);
      pen <= 1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (prdy !== 1'b1 && k < 50);
      if (prdy !== 1'b1) begin
         failures++;
         wrap_up;
      end
      rd = prd;
      er = perr;
      psel <= 0; pen <= 0;
   endtask

   task rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(0, a, 0);
      chk(rd, exp);
   endtask

   // polls the receive-done flag, bounded
   task wait_done;
      int k;
      k = 0;
      do begin
         apb(0, SPS_IRQ_ST_OFS, 0);
         k++;
      end while (rd[0] !== 1'b1 && k < 400);
      if (rd[0] !== 1'b1) begin
         failures++;
         wrap_up;
      end
   endtask

   task t_regs;
      chk(irq, 0);
      rd_chk(SPS_CTRL_OFS, 32'h0);
      rd_chk(SPS_STAT_OFS, 32'h0);
      apb(1, SPS_CTRL_OFS, 32'hdf);
      rd_chk(SPS_CTRL_OFS, 32'hdf);
      chk({sck_oe, sdo_oe}, 0);
      apb(1, SPS_STAT_OFS, 32'hff);
      rd_chk(SPS_STAT_OFS, 32'hc0);
      apb(1, SPS_CTRL_OFS, 32'h00);
      apb(0, 8'h10, 0);
      chk(er, 1);
      chk(rd, 0);
      $display("test regs done");
   endtask

   // master modes with polarity, edge and sample phase varied
   task automatic t_master;
      logic [7:0] st_t [4] = '{8'h40, 8'hc0, 8'h00, 8'h80};
      logic [3:0] md_t [4] = '{SPS_MODE_D16, SPS_MODE_D64, SPS_MODE_TMR,
                              SPS_MODE_D16};
      int         hp [4] = '{8, 32, 16, 8};
      logic [7:0] cfg;
      int         t0;
      for (logic [2:0] i = 0; i < 4; i++) begin
         cfg = {3'b001, i[0], md_t[i]};
         cke = st_t[i][6];
         ptx <= 8'h3c ^ i;
         apb(1, SPS_STAT_OFS, st_t[i]);
         apb(1, SPS_CTRL_OFS, cfg);
         apb(1, SPS_IRQ_MSK_OFS, i[0]);
         repeat (2) @(posedge clk);
         chk({sck_oe, sdo_oe, sck_o}, {2'b11, i[0]});
         t0 = tog;
         sel <= 1;
         apb(1, SPS_BUF_OFS, 8'ha5 + i);
         apb(1, SPS_BUF_OFS, 8'h00);
         rd_chk(SPS_CTRL_OFS, cfg | 8'h80);
         apb(1, SPS_CTRL_OFS, cfg);
         rd_chk(SPS_CTRL_OFS, cfg);
         wait_done;
         sel <= 0;
         chk(irq, i[0]);
         chk(tog - t0, 16);
         chk(tt[t0 + 15] - tt[t0], 15 * hp[i]);
         rd_chk(SPS_STAT_OFS, st_t[i] | 8'h01);
         rd_chk(SPS_BUF_OFS, 8'h3c ^ i);
         rd_chk(SPS_STAT_OFS, st_t[i]);
         chk(prx, 8'ha5 + i);
         apb(1, SPS_IRQ_ST_OFS, 1);
         @(posedge clk);
         chk(irq, 0);
         rd_chk(SPS_IRQ_ST_OFS, 0);
      end
      $display("test master done");
   endtask

   // slave with select control, then with select ignored
   task t_slave;
      for (logic [1:0] i = 0; i < 2; i++) begin
         cke = !i[0];
         ptx <= 8'h5a ^ i;
         apb(1, SPS_STAT_OFS, {1'b0, cke, 6'h00});
         apb(1, SPS_CTRL_OFS, i[0] ? 8'h25 : 8'h24);
         ss_n <= 1;
         repeat (8) @(posedge clk);
         chk({sck_oe, sdo_oe}, i[0]);
         ss_n <= i[0];
         sel <= 1;
         repeat (8) @(posedge clk);
         chk(sdo_oe, 1);
         apb(1, SPS_BUF_OFS, 8'h96 + i);
         repeat (16) begin
            repeat (16) @(posedge clk);
            ext_sck <= ~ext_sck;
         end
         wait_done;
         chk(irq, 1);
         sel <= 0;
         ss_n <= 1;
         rd_chk(SPS_BUF_OFS, 8'h5a ^ i);
         chk(prx, 8'h96 + i);
         // stale done flag would end the next poll early
         apb(1, SPS_IRQ_ST_OFS, 1);
      end
      $display("test slave done");
   endtask

   initial begin
      rst = 1; psel = 0; pen = 0; pwr = 0; paddr = 0; pwd = 0;
      ext_sck = 0; ss_n = 1; sel = 0; cke = 1;
      ptx = 0;
      repeat (8) @(posedge clk);
      rst <= 0;
      t_regs;
      t_master;
      t_slave;
      wrap_up;
   end
endmodule
